// file: cpsur_regs.sv
// clock path, sync and update register bank of the clock distribution device
`timescale 1ns/1ps
`default_nettype none
`include "cpsur_cfg.svh"
module cpsur_regs
  import cpsur_pkg::*;
(
  // clock and reset (serial port clock)
  input wire logic sys_clk,
  input wire logic rstn,
  // register access port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [`CPSUR_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // divider control
  output logic [2:0] div_ratio,
  output logic div_static,
  output logic div_bypass,
  output logic div_src_vco,
  // power-down and runt-protection controls
  output logic pd_clk_input,
  output logic pd_vco_if,
  output logic pd_vco_clk,
  output logic pd_sync,
  output logic pd_dist_ref,
  output logic antirunt_en,
  // sync controls
  output logic sync_hold,
  output logic sync_pulse
);
  cpsur_bank_if bank ();
  logic [7:0] buf_vcodiv;
  logic [7:0] buf_clkin;
  logic [7:0] buf_sys;
  logic upd_pend;
  logic soft_sync_q;
  logic [7:0] next_rdata;
  cpsur_vcodiv_t code;

  ////////////////////////////////////////////////////////////////////////////
  // buffer registers; bypass and VCO select kept exclusive
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      buf_vcodiv <= `CPSUR_RST_BYTE;
      buf_clkin <= `CPSUR_RST_BYTE;
      buf_sys <= `CPSUR_RST_BYTE;
    end else if (wr_en) begin
      case (addr)
        `CPSUR_OFF_VCODIV: begin
          buf_vcodiv <= wdata & `CPSUR_VCODIV_MASK;
        end
        `CPSUR_OFF_CLKIN: begin
          buf_clkin <= wdata & `CPSUR_CLKIN_MASK;
          if (wdata[`CPSUR_CLKIN_SEL_VCO]) begin
            buf_clkin[`CPSUR_CLKIN_BYPASS] <= 1'b0;
          end
        end
        `CPSUR_OFF_SYS: begin
          buf_sys <= wdata & `CPSUR_SYS_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // update strobe: set by write of one, clears after one transfer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      upd_pend <= 1'b0;
    end else begin
      upd_pend <= wr_en && addr == `CPSUR_OFF_UPD && wdata[`CPSUR_UPD_BIT];
    end
  end

  assign bank.buf_vcodiv = buf_vcodiv;
  assign bank.buf_clkin = buf_clkin;
  assign bank.buf_sys = buf_sys;
  assign bank.update = upd_pend;

  cpsur_active u_active (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .bank(bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux; buffer contents shown, update bit reads its pending state
  always_comb begin
    next_rdata = `CPSUR_RST_BYTE;
    case (addr)
      `CPSUR_OFF_VCODIV: next_rdata = buf_vcodiv;
      `CPSUR_OFF_CLKIN: next_rdata = buf_clkin;
      `CPSUR_OFF_SYS: next_rdata = buf_sys;
      `CPSUR_OFF_UPD: next_rdata = {7'h00, upd_pend};
      default: next_rdata = `CPSUR_RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `CPSUR_RST_BYTE;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of the active registers
  assign code = cpsur_vcodiv_t'(bank.act_vcodiv[2:0]);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_ratio <= 3'h2;
      div_static <= 1'b0;
      div_bypass <= 1'b0;
    end else begin
      case (code)
        CPSUR_DIV2: begin div_ratio <= 3'h2; div_static <= 1'b0; div_bypass <= 1'b0; end
        CPSUR_DIV3: begin div_ratio <= 3'h3; div_static <= 1'b0; div_bypass <= 1'b0; end
        CPSUR_DIV4: begin div_ratio <= 3'h4; div_static <= 1'b0; div_bypass <= 1'b0; end
        CPSUR_DIV5: begin div_ratio <= 3'h5; div_static <= 1'b0; div_bypass <= 1'b0; end
        CPSUR_DIV6: begin div_ratio <= 3'h6; div_static <= 1'b0; div_bypass <= 1'b0; end
        CPSUR_BYPASS: begin div_ratio <= 3'h1; div_static <= 1'b0; div_bypass <= 1'b1; end
        default: begin div_ratio <= 3'h0; div_static <= 1'b1; div_bypass <= 1'b0; end
      endcase
    end
  end

  // clock path and system controls from active registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pd_clk_input <= 1'b0;
      pd_vco_if <= 1'b0;
      pd_vco_clk <= 1'b0;
      div_src_vco <= 1'b0;
      pd_sync <= 1'b0;
      pd_dist_ref <= 1'b0;
      antirunt_en <= 1'b1;
      sync_hold <= 1'b0;
    end else begin
      pd_clk_input <= bank.act_clkin[`CPSUR_CLKIN_PD_ALL];
      pd_vco_if <= bank.act_clkin[`CPSUR_CLKIN_PD_IF];
      pd_vco_clk <= bank.act_clkin[`CPSUR_CLKIN_PD_SRC];
      div_src_vco <= bank.act_clkin[`CPSUR_CLKIN_SEL_VCO];
      pd_sync <= bank.act_sys[`CPSUR_SYS_PD_SYNC];
      pd_dist_ref <= bank.act_sys[`CPSUR_SYS_PD_DISTREF];
      antirunt_en <= !bank.act_sys[`CPSUR_SYS_NO_ANTIRUNT];
      sync_hold <= bank.act_sys[`CPSUR_SYS_SOFT_SYNC];
    end
  end

  // one-cycle sync pulse on falling soft sync
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      soft_sync_q <= 1'b0;
      sync_pulse <= 1'b0;
    end else begin
      soft_sync_q <= bank.act_sys[`CPSUR_SYS_SOFT_SYNC];
      sync_pulse <= soft_sync_q && !bank.act_sys[`CPSUR_SYS_SOFT_SYNC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_update_self_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    upd_pend && !(wr_en && addr == `CPSUR_OFF_UPD) |=> !upd_pend)
    else $error("update bit did not clear");
  chk_update_launch: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_en && addr == `CPSUR_OFF_UPD && wdata[`CPSUR_UPD_BIT] |=> upd_pend)
    else $error("update write not taken");
  chk_exclusive_sel: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(buf_clkin[`CPSUR_CLKIN_SEL_VCO] && buf_clkin[`CPSUR_CLKIN_BYPASS]))
    else $error("bypass and VCO select both set");
  chk_pd_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
    upd_pend ##1 1'b1 |=> pd_clk_input == $past(buf_clkin[`CPSUR_CLKIN_PD_ALL], 2))
    else $error("clock input power-down not applied");
  chk_bypass_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
    code == CPSUR_BYPASS |=> div_bypass && div_ratio == 3'h1)
    else $error("bypass code not decoded");
  chk_sync_falling: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(bank.act_sys[`CPSUR_SYS_SOFT_SYNC]) |=> sync_pulse ##1 !sync_pulse)
    else $error("soft sync falling edge missed");
  chk_antirunt: assert property (@(posedge sys_clk) disable iff (!rstn)
    bank.act_sys[`CPSUR_SYS_NO_ANTIRUNT] |=> !antirunt_en)
    else $error("runt protection not disabled");
  chk_pd_sync: assert property (@(posedge sys_clk) disable iff (!rstn)
    bank.act_sys[`CPSUR_SYS_PD_SYNC] |=> pd_sync)
    else $error("sync power-down missing");
  cov_update: cover property (@(posedge sys_clk) disable iff (!rstn) upd_pend ##1 !upd_pend);
  cov_soft_sync: cover property (@(posedge sys_clk) disable iff (!rstn) sync_pulse);
  cov_static: cover property (@(posedge sys_clk) disable iff (!rstn) div_static);
endmodule
`default_nettype wire

// file: cpsur_cfg.svh
// register map constants for the clock path, sync and update register bank
`ifndef CPSUR_CFG_SVH
`define CPSUR_CFG_SVH
`define CPSUR_ADDR_W 12
`define CPSUR_OFF_VCODIV 12'h1E0
`define CPSUR_OFF_CLKIN 12'h01E
`define CPSUR_OFF_SYS 12'h230
`define CPSUR_OFF_UPD 12'h232
`define CPSUR_CLKIN_PD_ALL 4
`define CPSUR_CLKIN_PD_IF 3
`define CPSUR_CLKIN_PD_SRC 2
`define CPSUR_CLKIN_SEL_VCO 1
`define CPSUR_CLKIN_BYPASS 0
`define CPSUR_SYS_NO_ANTIRUNT 3
`define CPSUR_SYS_PD_SYNC 2
`define CPSUR_SYS_PD_DISTREF 1
`define CPSUR_SYS_SOFT_SYNC 0
`define CPSUR_UPD_BIT 0
`define CPSUR_CLKIN_MASK 8'h1F
`define CPSUR_SYS_MASK 8'h0F
`define CPSUR_VCODIV_MASK 8'h07
`define CPSUR_RST_BYTE 8'h00
`endif

// file: cpsur_pkg.sv
// types shared by the clock path, sync and update register bank
package cpsur_pkg;
  typedef enum logic [2:0] {
    CPSUR_DIV2 = 3'h0,
    CPSUR_DIV3 = 3'h1,
    CPSUR_DIV4 = 3'h2,
    CPSUR_DIV5 = 3'h3,
    CPSUR_DIV6 = 3'h4,
    CPSUR_STATIC_A = 3'h5,
    CPSUR_BYPASS = 3'h6,
    CPSUR_STATIC_B = 3'h7
  } cpsur_vcodiv_t;
endpackage

// file: cpsur_bank_if.sv
// carrier between the register front and the active-register stage
`timescale 1ns/1ps
`default_nettype none
interface cpsur_bank_if;
  logic [7:0] buf_vcodiv;
  logic [7:0] buf_clkin;
  logic [7:0] buf_sys;
  logic update;
  logic [7:0] act_vcodiv;
  logic [7:0] act_clkin;
  logic [7:0] act_sys;
  modport front (output buf_vcodiv, buf_clkin, buf_sys, update, input act_vcodiv, act_clkin, act_sys);
  modport active (input buf_vcodiv, buf_clkin, buf_sys, update, output act_vcodiv, act_clkin, act_sys);
endinterface
`default_nettype wire

// file: cpsur_active.sv
// active-register stage loaded from the buffer registers on update
`timescale 1ns/1ps
`default_nettype none
`include "cpsur_cfg.svh"
module cpsur_active
  import cpsur_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // bank carrier
  cpsur_bank_if.active bank
);
  // copy on the edge after the update strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bank.act_vcodiv <= `CPSUR_RST_BYTE;
      bank.act_clkin <= `CPSUR_RST_BYTE;
      bank.act_sys <= `CPSUR_RST_BYTE;
    end else if (bank.update) begin
      bank.act_vcodiv <= bank.buf_vcodiv;
      bank.act_clkin <= bank.buf_clkin;
      bank.act_sys <= bank.buf_sys;
    end
  end

  chk_copy_on_update: assert property (@(posedge sys_clk) disable iff (!rstn)
    bank.update |=> bank.act_clkin == $past(bank.buf_clkin))
    else $error("active clock input register not loaded on update");
  chk_hold_no_update: assert property (@(posedge sys_clk) disable iff (!rstn)
    !bank.update |=> $stable(bank.act_sys))
    else $error("active system register changed without update");
endmodule
`default_nettype wire

// file: cpsur_host.sv
// host model driving the serial register port of the bank
`timescale 1ns/1ps
`default_nettype none
`include "cpsur_cfg.svh"
module cpsur_host (
  // clock
  input wire logic sys_clk,
  // register access port
  output logic wr_en,
  output logic rd_en,
  output logic [`CPSUR_ADDR_W-1:0] addr,
  output logic [7:0] wdata
);
  // idle bus at time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
  end
  // one access held across one rising edge, then the idle bus is scrambled
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wr_en = w;
    rd_en = ~w;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  // update strobe: one write of one to the update bit
  task automatic update();
    acc(1'b1, `CPSUR_OFF_UPD, 8'h01);
  endtask
endmodule
`default_nettype wire

// file: clock_path_sync_update_regs_bench.sv
// self-checking bench for the clock path, sync and update register bank
`timescale 1ns/1ps
`default_nettype none
`include "cpsur_cfg.svh"
module clock_path_sync_update_regs_bench;
  import cpsur_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_en, rd_en, div_static, div_bypass, div_src_vco, pd_clk_input, pd_vco_if;
  logic pd_vco_clk, pd_sync, pd_dist_ref, antirunt_en, sync_hold, sync_pulse;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, r;
  logic [2:0] div_ratio;
  logic [7:0] b_d = 8'h00, b_c = 8'h00, b_s = 8'h00, a_d = 8'h00, a_c = 8'h00, a_s = 8'h00;
  logic [12:0] notes[$];
  logic [3:0] p = 4'h0;
  logic rd_d = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'h39108068;
  wire [12:0] ctl = {div_ratio, div_static, div_bypass, div_src_vco, pd_clk_input, pd_vco_if,
                     pd_vco_clk, pd_sync, pd_dist_ref, antirunt_en, sync_hold};
  always #5 sys_clk = ~sys_clk;
  cpsur_regs i_cpsur_regs (.sys_clk(sys_clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .div_ratio(div_ratio), .div_static(div_static), .div_bypass(div_bypass),
    .div_src_vco(div_src_vco), .pd_clk_input(pd_clk_input), .pd_vco_if(pd_vco_if), .pd_vco_clk(pd_vco_clk),
    .pd_sync(pd_sync), .pd_dist_ref(pd_dist_ref), .antirunt_en(antirunt_en), .sync_hold(sync_hold),
    .sync_pulse(sync_pulse));
  cpsur_host i_cpsur_host (.sys_clk(sys_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
  ////////////////////////////////////////////////////////////////////////////////
  // expected control outputs from divider, clock input and system bytes
  function automatic logic [12:0] ctrl(input logic [7:0] d, input logic [7:0] c, input logic [7:0] s);
    logic [2:0] q;
    q = (d[2:0] < 3'h5) ? d[2:0] + 3'h2 : ((d[2:0] == 3'h6) ? 3'h1 : 3'h0);
    return {q, d[2:0] == 3'h5 || d[2:0] == 3'h7, d[2:0] == 3'h6, c[1], c[4], c[3], c[2], s[2], s[1], ~s[3], s[0]};
  endfunction
  task automatic chk(input string n, input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // buffer write with the masks the bank applies
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_cpsur_host.acc(1'b1, a, d);
    case (a)
      `CPSUR_OFF_VCODIV: b_d = d & `CPSUR_VCODIV_MASK;
      `CPSUR_OFF_CLKIN: b_c = d & `CPSUR_CLKIN_MASK & (d[1] ? 8'hFE : 8'hFF);
      `CPSUR_OFF_SYS: b_s = d & `CPSUR_SYS_MASK;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    notes.push_back({5'h00, e});
    i_cpsur_host.acc(1'b0, a, 8'h00);
  endtask
  // read every mapped place plus one unmapped address
  task automatic rdall();
    rd(`CPSUR_OFF_VCODIV, b_d);
    rd(`CPSUR_OFF_CLKIN, b_c);
    rd(`CPSUR_OFF_SYS, b_s);
    rd(`CPSUR_OFF_UPD, 8'h00);
    rd(12'h100, 8'h00);
  endtask
  // update: old controls one edge on, new ones and the sync pulse the edge after
  task automatic upd();
    notes.push_back(ctrl(a_d, a_c, a_s));
    notes.push_back(ctrl(b_d, b_c, b_s));
    notes.push_back({12'h000, a_s[0] & ~b_s[0]});
    notes.push_back(13'h0000);
    i_cpsur_host.update();
    a_d = b_d;
    a_c = b_c;
    a_s = b_s;
    repeat (4) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // track accepted reads and update writes
  always @(posedge sys_clk) begin
    p <= {p[2:0], rstn && wr_en && addr == `CPSUR_OFF_UPD && wdata[0]};
    rd_d <= rd_en;
  end
  // compare each result against the oldest note
  always @(negedge sys_clk) begin
    if (rd_d) chk("rdata", {5'h00, rdata}, notes.pop_front());
    if (p[1]) chk("controls before update", ctl, notes.pop_front());
    if (p[2]) chk("controls after update", ctl, notes.pop_front());
    if (p[2]) chk("sync pulse", {12'h000, sync_pulse}, notes.pop_front());
    if (p[3]) chk("sync pulse end", {12'h000, sync_pulse}, notes.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; watchdog well beyond the few hundred cycles expected
  initial begin
    fork
      begin
        #200000;
        fails++;
        conclude();
      end
    join_none
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    rdall();
    upd();
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      wr(`CPSUR_OFF_VCODIV, {r[7:3], i[2:0]});
      r = 8'($random(seed));
      // host never asks for bypass while the vco source is chosen
      wr(`CPSUR_OFF_CLKIN, r & (r[1] ? 8'hFE : 8'hFF));
      r = 8'($random(seed));
      wr(`CPSUR_OFF_SYS, r);
      wr(12'h100, r);
      rdall();
      upd();
      rdall();
    end
    // deliberate probe: the bank must drop bypass when vco is selected
    wr(`CPSUR_OFF_CLKIN, 8'h03);
    wr(`CPSUR_OFF_SYS, 8'h01);
    upd();
    wr(`CPSUR_OFF_SYS, 8'h00);
    upd();
    rdall();
    conclude();
  end
endmodule
`default_nettype wire
